//--- rtl/lds_pkg.sv
// Operation
// RULE_01: power up only after enable held high for first on-time and lockout clear.
// RULE_02: no power-up while sync pin held low; go once released or clocked.
// RULE_03: after lockout and enable, drive disconnect switch, then check every sink pin.
// RULE_04: detect phase starts only once disconnect gate reaches its threshold.
// RULE_05: after pin exceeds 120 mV, wait 3000 to 4000 switching ticks, then classify.
// RULE_06: pin below 70 mV is shorted; halt, withhold soft start, re-check after removal.
// RULE_07: pin near 150 mV is unused and dropped; near 325 mV is in use.
// RULE_08: soft start uses soft-start sink current and reduced switch current limit.
// RULE_09: enough sink voltage ends soft start: full current and normal switch limit.
// RULE_10: sync pin shorted to ground during operation shuts the device down.
// RULE_11: detected external clock takes over switching without disturbing sink current.
// RULE_12: host keeps every sync high and low phase at least 150 ns.
// RULE_13: sync lost: stop switching at most about 7 us, then internal clock.
// RULE_14: sync pin low beyond 7 us: stop switching, open disconnect, stop sinks.
// RULE_15: sync pin released after that shutdown restarts through soft start.
// RULE_16: enable low for 32,750 switching ticks powers the device down.
// RULE_17: host changes clock source 500 ns after enable rise or while enable low.
// RULE_18: host holds enable high for first on-time, 0.75 us typical, 2 us max.
// RULE_19: soft start drives each enabled sink at fixed soft-start current.
// RULE_20: detect and shutdown counters run on switching ticks, clear when cause ends.
// RULE_21: lockout return or any shutdown sends the sequencer to its initial state; code sends sync-pin shutdowns to ST_HALT, which resumes in ST_SOFT.
package lds_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FIRST_ON_TIME_NS = 750;
  localparam int FIRST_ON_CYCLES = (FIRST_ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LOSS_NS = 7000;
  localparam int SYNC_LOSS_CYCLES = SYNC_LOSS_NS / CLK_PERIOD_NS;
  localparam int SYNC_PERIOD_MAX_NS = 4000;
  localparam int SYNC_PERIOD_MAX_CYCLES = (SYNC_PERIOD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_TICKS_MIN = 3000;
  localparam int DETECT_TICKS_MAX = 4000;
  localparam int DETECT_TICKS_DEF = 3500;
  localparam int LOW_POWER_TICKS = 32750;
  localparam int INT_OSC_DIV = 25;
  localparam int CHANNELS = 2;
  localparam int IN_ENABLE = 0;
  localparam int IN_LOCKOUT = 1;
  localparam int IN_FREL = 2;
  localparam int IN_FSHORT = 3;
  localparam int IN_GATE = 4;
  localparam int IN_CHAN = 5;
  localparam int CH_ABOVE = 0;
  localparam int CH_SHORT = 1;
  localparam int CH_INUSE = 2;
  localparam int CH_REGOK = 3;
  localparam int CH_FIELDS = 4;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_GATE,
    ST_DETECT,
    ST_SHORT_HOLD,
    ST_SOFT,
    ST_RUN,
    ST_HALT
  } lds_state_t;
endpackage

//--- rtl/lds_clk_if.sv
interface lds_clk_if;
  logic sw_tick;
  logic sync_active;
  logic switch_hold;
  logic stuck_low;
  modport src(
    output sw_tick,
    output sync_active,
    output switch_hold,
    output stuck_low
  );
  modport snk(
    input sw_tick,
    input sync_active,
    input switch_hold,
    input stuck_low
  );
endinterface

//--- rtl/lds_clock_source.sv
module lds_clock_source #(
  parameter int INT_DIV = lds_pkg::INT_OSC_DIV,
  parameter int LOSS_CYCLES = lds_pkg::SYNC_LOSS_CYCLES,
  parameter int PERIOD_MAX_CYCLES = lds_pkg::SYNC_PERIOD_MAX_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic freq_set_sync_pin,
  lds_clk_if.src clk
);
  logic s1_reg, s2_reg, s3_reg, level_reg, prev_reg;
  logic [9:0] gap_reg;
  logic [7:0] div_reg;
  logic active_reg, tick_reg, stuck_reg, hold_reg;
  wire level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
  wire rise = level_reg & ~prev_reg;
  wire any_edge = level_reg ^ prev_reg;
  wire gap_expired = (gap_reg == 10'(LOSS_CYCLES));
  wire gap_late = (gap_reg > 10'(PERIOD_MAX_CYCLES));
  wire div_wrap = (div_reg == 8'(INT_DIV - 1));

  always_ff @(posedge mclk)
  begin
    // released pin idles high: a low reset value would fake a first sync edge
    s1_reg <= reset ? 1'b1 : freq_set_sync_pin;
    s2_reg <= reset ? 1'b1 : s1_reg;
    s3_reg <= reset ? 1'b1 : s2_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      level_reg <= 1'b1;
      prev_reg <= 1'b1;
      gap_reg <= '0;
      active_reg <= 1'b0;
      div_reg <= '0;
      tick_reg <= 1'b0;
      stuck_reg <= 1'b0;
      hold_reg <= 1'b0;
    end
    else
    begin
      level_reg <= level_next;
      prev_reg <= level_reg;
      // gap counter saturates so a stuck pin keeps its verdict
      if (any_edge)
        gap_reg <= '0;
      else if (!gap_expired)
        gap_reg <= gap_reg + 10'd1;
      if (rise)
        active_reg <= 1'b1; // [RULE_11]
      else if (gap_expired)
        active_reg <= 1'b0; // [RULE_13]
      // divider restarts on fallback so the first internal period is whole
      if (active_reg || div_wrap)
        div_reg <= '0;
      else
        div_reg <= div_reg + 8'd1;
      // external edges become ticks directly: no phase jump in the sinks
      tick_reg <= active_reg ? (rise & ~hold_reg) : div_wrap; // [RULE_11]
      hold_reg <= active_reg & gap_late & ~gap_expired & ~any_edge; // [RULE_13]
      stuck_reg <= gap_expired & ~level_reg & ~any_edge; // [RULE_14]
    end
  end

  assign clk.sw_tick = tick_reg;
  assign clk.sync_active = active_reg;
  assign clk.switch_hold = hold_reg;
  assign clk.stuck_low = stuck_reg;
endmodule

//--- rtl/lds_sequencer.sv
module lds_sequencer #(
  parameter int CHANNELS = lds_pkg::CHANNELS,
  parameter logic [11:0] DETECT_TICKS = 12'(lds_pkg::DETECT_TICKS_DEF),
  parameter logic [15:0] LOW_POWER_TICKS = 16'(lds_pkg::LOW_POWER_TICKS),
  parameter int INT_DIV = lds_pkg::INT_OSC_DIV
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable_dimming_pin,
  input wire logic lockout_clear,
  input wire logic freq_set_released,
  input wire logic freq_set_shorted,
  input wire logic freq_set_sync_pin,
  input wire logic gate_at_threshold,
  input wire logic [CHANNELS-1:0] led_above_detect,
  input wire logic [CHANNELS-1:0] led_below_short,
  input wire logic [CHANNELS-1:0] led_in_use,
  input wire logic [CHANNELS-1:0] led_regulation_ok,
  output logic disconnect_gate_on,
  output logic [CHANNELS-1:0] sink_enable,
  output logic sink_softstart,
  output logic softstart_switch_limit,
  output logic switching_enable,
  output logic switch_clock_tick,
  output logic clock_external,
  output logic [CHANNELS-1:0] channel_shorted,
  output logic [CHANNELS-1:0] channel_unused,
  output logic shutdown_active,
  output logic [2:0] sequencer_state
);
  localparam int IN_W = lds_pkg::IN_CHAN + lds_pkg::CH_FIELDS * CHANNELS;

  lds_clk_if clk_bus();

  lds_clock_source #(
    .INT_DIV(INT_DIV),
    .LOSS_CYCLES(lds_pkg::SYNC_LOSS_CYCLES),
    .PERIOD_MAX_CYCLES(lds_pkg::SYNC_PERIOD_MAX_CYCLES)
  ) u_clock_source (
    .mclk(mclk),
    .reset(reset),
    .freq_set_sync_pin(freq_set_sync_pin),
    .clk(clk_bus.src)
  );

  // pin comparators are asynchronous to mclk
  logic [IN_W-1:0] pin_raw, s1_reg, s2_reg, s3_reg, pin_reg;
  logic [IN_W-1:0] pin_next;
  wire [IN_W-1:0] agree = ~(s2_reg ^ s3_reg);
  assign pin_raw = {led_regulation_ok, led_in_use, led_below_short, led_above_detect,
                    gate_at_threshold, freq_set_shorted, freq_set_released, lockout_clear,
                    enable_dimming_pin};

  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++)
    begin : g_filter
      assign pin_next[gi] = agree[gi] ? s3_reg[gi] : pin_reg[gi];
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    s1_reg <= reset ? '0 : pin_raw;
    s2_reg <= reset ? '0 : s1_reg;
    s3_reg <= reset ? '0 : s2_reg;
    pin_reg <= reset ? '0 : pin_next;
  end

  function automatic logic [CHANNELS-1:0] chan_field(input logic [IN_W-1:0] v, input int f);
    logic [CHANNELS-1:0] r;
    r = '0;
    for (int k = 0; k < CHANNELS; k++)
      r[k] = v[lds_pkg::IN_CHAN + f * CHANNELS + k];
    return r;
  endfunction

  wire en_lvl = pin_reg[lds_pkg::IN_ENABLE];
  wire lock_ok = pin_reg[lds_pkg::IN_LOCKOUT];
  wire fset_rel = pin_reg[lds_pkg::IN_FREL];
  wire fset_short = pin_reg[lds_pkg::IN_FSHORT];
  wire gate_ok = pin_reg[lds_pkg::IN_GATE];
  wire [CHANNELS-1:0] ch_above = chan_field(pin_reg, lds_pkg::CH_ABOVE);
  wire [CHANNELS-1:0] ch_short = chan_field(pin_reg, lds_pkg::CH_SHORT);
  wire [CHANNELS-1:0] ch_inuse = chan_field(pin_reg, lds_pkg::CH_INUSE);
  wire [CHANNELS-1:0] ch_regok = chan_field(pin_reg, lds_pkg::CH_REGOK);
  wire tick = clk_bus.sw_tick;

  lds_pkg::lds_state_t state_reg, state_next;
  logic [5:0] on_cnt_reg;
  logic [11:0] det_cnt_reg;
  logic [15:0] low_cnt_reg;
  logic [CHANNELS-1:0] used_reg, used_next, short_reg, short_next;

  wire first_on_met = (on_cnt_reg == 6'(lds_pkg::FIRST_ON_CYCLES));
  wire pin_free = fset_rel | clk_bus.sync_active;
  wire start_ok = lock_ok & en_lvl & first_on_met & pin_free & ~fset_short;
  wire in_detect = (state_reg == lds_pkg::ST_DETECT);
  wire det_running = in_detect & (|ch_above);
  wire det_done = det_running & tick & (det_cnt_reg == DETECT_TICKS - 12'd1);
  wire powered = (state_reg == lds_pkg::ST_SOFT) || (state_reg == lds_pkg::ST_RUN)
                 || (state_reg == lds_pkg::ST_HALT);
  wire low_done = powered & ~en_lvl & tick & (low_cnt_reg == LOW_POWER_TICKS - 16'd1);
  wire reg_ready = ((ch_regok & used_reg) == used_reg);
  wire operating = (state_reg != lds_pkg::ST_OFF) && (state_reg != lds_pkg::ST_HALT);
  wire go_halt = operating & (fset_short | clk_bus.stuck_low);

  always_comb
  begin
    state_next = state_reg;
    used_next = used_reg;
    short_next = short_reg;
    case (state_reg)
      lds_pkg::ST_OFF:
        if (start_ok)
          state_next = lds_pkg::ST_GATE; // [RULE_01] [RULE_02] [RULE_03]
      lds_pkg::ST_GATE:
        if (gate_ok)
          state_next = lds_pkg::ST_DETECT; // [RULE_04]
      lds_pkg::ST_DETECT:
        if (det_done)
        begin
          short_next = ch_short; // [RULE_05]
          used_next = ch_inuse & ~ch_short; // [RULE_07]
          if (|ch_short)
            state_next = lds_pkg::ST_SHORT_HOLD; // [RULE_06]
          else
            state_next = lds_pkg::ST_SOFT;
        end
      lds_pkg::ST_SHORT_HOLD:
        if (!(|(ch_short & short_reg)))
          state_next = lds_pkg::ST_DETECT; // [RULE_06]
      lds_pkg::ST_SOFT:
        if (reg_ready && (|used_reg))
          state_next = lds_pkg::ST_RUN; // [RULE_09]
      lds_pkg::ST_RUN:
        state_next = lds_pkg::ST_RUN;
      lds_pkg::ST_HALT:
        // only a clean pin lets the supply come back, and always softly
        if (!fset_short && !clk_bus.stuck_low && pin_free)
          state_next = lds_pkg::ST_SOFT; // [RULE_15]
      default:
        state_next = lds_pkg::ST_OFF;
    endcase
    if (go_halt)
      state_next = lds_pkg::ST_HALT; // [RULE_10] [RULE_14] [RULE_21]
    if (low_done || !lock_ok)
    begin
      state_next = lds_pkg::ST_OFF; // [RULE_16] [RULE_21]
      used_next = '0;
      short_next = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      state_reg <= lds_pkg::ST_OFF;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      used_reg <= '0;
      short_reg <= '0;
    end
    else
    begin
      used_reg <= used_next;
      short_reg <= short_next;
    end
  end

  // first on-time is measured on mclk, not on switching ticks
  always_ff @(posedge mclk)
  begin
    if (reset || !en_lvl)
      on_cnt_reg <= '0;
    else if (!first_on_met)
      on_cnt_reg <= on_cnt_reg + 6'd1; // [RULE_01]
  end

  always_ff @(posedge mclk)
  begin
    if (reset || !det_running)
      det_cnt_reg <= '0; // [RULE_20]
    else if (tick)
      det_cnt_reg <= det_done ? '0 : det_cnt_reg + 12'd1; // [RULE_05] [RULE_20]
  end

  always_ff @(posedge mclk)
  begin
    if (reset || en_lvl || !powered)
      low_cnt_reg <= '0; // [RULE_20]
    else if (tick)
      low_cnt_reg <= low_cnt_reg + 16'd1; // [RULE_16]
  end

  wire st_soft = (state_next == lds_pkg::ST_SOFT);
  wire st_run = (state_next == lds_pkg::ST_RUN);
  wire st_sink = st_soft | st_run;
  wire gate_next = (state_next != lds_pkg::ST_OFF) && (state_next != lds_pkg::ST_HALT);
  // enable low is plain dimming: sinks and switch pause, state is kept
  wire [CHANNELS-1:0] sink_next = (st_sink && en_lvl) ? used_next : '0;
  wire switch_next = st_sink & en_lvl & ~clk_bus.switch_hold;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      disconnect_gate_on <= 1'b0;
      sink_enable <= '0;
      sink_softstart <= 1'b0;
      softstart_switch_limit <= 1'b0;
      switching_enable <= 1'b0;
      switch_clock_tick <= 1'b0;
      clock_external <= 1'b0;
      channel_shorted <= '0;
      channel_unused <= '0;
      shutdown_active <= 1'b0;
      sequencer_state <= 3'h0;
    end
    else
    begin
      disconnect_gate_on <= gate_next; // [RULE_03] [RULE_14]
      sink_enable <= sink_next; // [RULE_07] [RULE_14]
      sink_softstart <= st_soft; // [RULE_08] [RULE_19]
      softstart_switch_limit <= st_soft; // [RULE_08] [RULE_09]
      switching_enable <= switch_next; // [RULE_13] [RULE_14]
      switch_clock_tick <= tick & switch_next; // [RULE_11]
      clock_external <= clk_bus.sync_active; // [RULE_11]
      channel_shorted <= short_next; // [RULE_06]
      channel_unused <= (st_sink || state_next == lds_pkg::ST_HALT) ? ~used_next : '0; // [RULE_07]
      shutdown_active <= (state_next == lds_pkg::ST_HALT); // [RULE_10] [RULE_14]
      sequencer_state <= state_next;
    end
  end
endmodule

//--- tb/lds_sequencer_props.sv
module lds_sequencer_props #(
  parameter int CHANNELS = 2
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable_dimming_pin,
  input wire logic lockout_clear,
  input wire logic freq_set_shorted,
  input wire logic disconnect_gate_on,
  input wire logic [CHANNELS-1:0] sink_enable,
  input wire logic sink_softstart,
  input wire logic softstart_switch_limit,
  input wire logic switching_enable,
  input wire logic clock_external,
  input wire logic shutdown_active,
  input wire logic [2:0] sequencer_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  soft_limits_a: assert property (sequencer_state == 3'h4 |-> sink_softstart && softstart_switch_limit)
    else $error("soft start limits wrong");
  run_limits_a: assert property (sequencer_state == 3'h5 |-> !sink_softstart && !softstart_switch_limit)
    else $error("run limits wrong");
  off_quiet_a: assert property (sequencer_state == 3'h0 |-> !disconnect_gate_on && !switching_enable)
    else $error("outputs active while off");
  lockout_off_a: assert property (!lockout_clear [*8] |-> ##[0:4] sequencer_state == 3'h0)
    else $error("lockout did not reset sequencer");
  detect_entry_a: assert property (sequencer_state == 3'h2 && $past(sequencer_state) != 3'h2
    |-> $past(sequencer_state) inside {3'h1, 3'h3} && disconnect_gate_on) else $error("detect entered early");
  pin_short_a: assert property ($rose(freq_set_shorted) && sequencer_state == 3'h5 |-> ##[1:8] sequencer_state == 3'h6)
    else $error("pin short did not shut down");
  halt_quiet_a: assert property (sequencer_state == 3'h6 |-> shutdown_active && !disconnect_gate_on && !switching_enable
    && sink_enable == '0) else $error("halt outputs wrong");
  enable_gate_a: assert property ((sequencer_state == 3'h0 && !enable_dimming_pin) [*8] |=> sequencer_state == 3'h0)
    else $error("power-up without enable");
  sync_resume_a: assert property ($fell(switching_enable) && enable_dimming_pin && sequencer_state == 3'h5
    |-> ##[1:400] (switching_enable || sequencer_state != 3'h5)) else $error("switching pause too long");
  cover property (sequencer_state == 3'h5 && clock_external);
  cover property (sequencer_state == 3'h6);
  cover property (sequencer_state == 3'h3);
endmodule

bind lds_sequencer lds_sequencer_props #(.CHANNELS(CHANNELS)) i_lds_sequencer_props (.mclk, .reset, .enable_dimming_pin,
  .lockout_clear, .freq_set_shorted, .disconnect_gate_on, .sink_enable, .sink_softstart, .softstart_switch_limit,
  .switching_enable, .clock_external, .shutdown_active, .sequencer_state);

//--- tb/lds_host_model.sv
module lds_host_model (
  input wire logic mclk,
  input wire logic en_req,
  input wire logic keep_on,
  input wire logic [1:0] sync_mode,
  output logic enable_dimming_pin,
  output logic freq_set_sync_pin,
  output logic freq_set_released
);
  timeunit 1ns;
  timeprecision 1ps;
  int on_cnt = 0;
  int ph = 0;
  logic [1:0] mode = 2'h0;
  initial enable_dimming_pin = 1'b0;
  always @(posedge mclk)
  begin
    #1;
    ph = (ph + 1) % 50;
    on_cnt = enable_dimming_pin ? on_cnt + 1 : 0;
    enable_dimming_pin = en_req || (keep_on && enable_dimming_pin && on_cnt < 40);
    // source swap only while dark or well after the rising edge
    if (!enable_dimming_pin || on_cnt > 25)
      mode = sync_mode;
  end
  // 1 MHz sync, 500 ns phases
  assign freq_set_sync_pin = (mode == 2'h1) ? (ph < 25) : (mode == 2'h0);
  assign freq_set_released = freq_set_sync_pin;
endmodule

//--- tb/lds_sequencer_test.sv
module lds_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
  `define WAITFOR(c, lim) begin n = 0; while (!(c) && n < (lim)) begin step(1); n++; end end
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic lockout_clear = 1'b0, freq_set_shorted = 1'b0, gate_at_threshold = 1'b0, en_req = 1'b0, keep_on = 1'b1;
  logic [1:0] led_above_detect = 2'h0, led_below_short = 2'h0, led_in_use = 2'h0, led_regulation_ok = 2'h0;
  logic [1:0] sync_mode = 2'h0;
  logic enable_dimming_pin, freq_set_sync_pin, freq_set_released, disconnect_gate_on, sink_softstart;
  logic softstart_switch_limit, switching_enable, switch_clock_tick, clock_external, shutdown_active;
  logic [1:0] sink_enable, channel_shorted, channel_unused;
  logic [2:0] sequencer_state;
  always #10 mclk = ~mclk;
  lds_host_model i_lds_host_model (.mclk, .en_req, .keep_on, .sync_mode, .enable_dimming_pin, .freq_set_sync_pin,
    .freq_set_released);
  lds_sequencer #(.DETECT_TICKS(12'h014), .LOW_POWER_TICKS(16'h0028)) i_lds_sequencer (.mclk, .reset, .enable_dimming_pin,
    .lockout_clear, .freq_set_released, .freq_set_shorted, .freq_set_sync_pin, .gate_at_threshold, .led_above_detect,
    .led_below_short, .led_in_use, .led_regulation_ok, .disconnect_gate_on, .sink_enable, .sink_softstart,
    .softstart_switch_limit, .switching_enable, .switch_clock_tick, .clock_external, .channel_shorted, .channel_unused,
    .shutdown_active, .sequencer_state);
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic tick_gap(output int g);
    `WAITFOR(switch_clock_tick === 1'b1, 100)
    g = 0;
    do
    begin
      step(1);
      g++;
    end while (switch_clock_tick !== 1'b1 && g < 100);
  endtask
  task automatic power_up(input logic [1:0] use_mask, input logic [1:0] shorts);
    led_in_use = use_mask;
    led_below_short = shorts;
    led_above_detect = ~shorts;
    led_regulation_ok = 2'h0;
    gate_at_threshold = 1'b0;
    lockout_clear = 1'b1;
    en_req = 1'b1;
    `WAITFOR(sequencer_state === 3'h1, 200)
    `CHK(disconnect_gate_on, 1'b1)
    step(30);
    `CHK(sequencer_state, 3'h1)
    gate_at_threshold = 1'b1;
    `WAITFOR(sequencer_state === 3'h2, 50)
    `CHK(sequencer_state, 3'h2)
    `WAITFOR(sequencer_state === ((shorts != 2'h0) ? 3'h3 : 3'h4), 800)
    // 20 ticks of 25 mclk plus pin filter latency
    `CHK(n >= 470 && n <= 560, 1'b1)
  endtask
  task automatic t_refused;
    keep_on = 1'b0;
    en_req = 1'b1;
    step(100);
    `CHK(sequencer_state, 3'h0)
    en_req = 1'b0;
    lockout_clear = 1'b1;
    step(5);
    en_req = 1'b1;
    step(20);
    en_req = 1'b0;
    step(60);
    `CHK(sequencer_state, 3'h0)
    keep_on = 1'b1;
    sync_mode = 2'h2;
    step(5);
    en_req = 1'b1;
    step(100);
    `CHK(sequencer_state, 3'h0)
    en_req = 1'b0;
    sync_mode = 2'h0;
    // a released pin reads as one sync edge; let that detection lapse
    step(400);
  endtask
  task automatic t_normal;
    power_up(2'h1, 2'h0);
    `CHK({sink_softstart, softstart_switch_limit}, 2'h3)
    `CHK(sink_enable, 2'h1)
    `CHK(channel_unused, 2'h2)
    led_regulation_ok = 2'h1;
    `WAITFOR(sequencer_state === 3'h5, 20)
    `CHK({sink_softstart, softstart_switch_limit, sink_enable}, 4'h1)
  endtask
  task automatic t_sync;
    int g;
    sync_mode = 2'h1;
    `WAITFOR(clock_external === 1'b1, 300)
    `CHK({clock_external, sink_enable}, 3'h5)
    tick_gap(g);
    `CHK(g, 50)
    sync_mode = 2'h0;
    `WAITFOR(switching_enable === 1'b0, 300)
    `CHK(switching_enable, 1'b0)
    `WAITFOR(switching_enable === 1'b1, 400)
    `CHK(n <= 360, 1'b1)
    `CHK({clock_external, sequencer_state}, 4'h5)
    tick_gap(g);
    `CHK(g, 25)
  endtask
  task automatic t_sync_low;
    sync_mode = 2'h1;
    `WAITFOR(clock_external === 1'b1, 300)
    sync_mode = 2'h2;
    `WAITFOR(sequencer_state === 3'h6, 500)
    `CHK(n >= 300 && n <= 370, 1'b1)
    `CHK({disconnect_gate_on, sink_enable, switching_enable, shutdown_active}, 5'h01)
    sync_mode = 2'h0;
    `WAITFOR(sequencer_state === 3'h4, 100)
    `CHK(sequencer_state, 3'h4)
    `WAITFOR(sequencer_state === 3'h5, 50)
    `CHK(sequencer_state, 3'h5)
    freq_set_shorted = 1'b1;
    `WAITFOR(sequencer_state === 3'h6, 50)
    `CHK(sequencer_state, 3'h6)
    freq_set_shorted = 1'b0;
    `WAITFOR(sequencer_state === 3'h5, 100)
    `CHK(sequencer_state, 3'h5)
  endtask
  task automatic t_low_power;
    // two 28-tick gaps: together past the limit unless the count restarts
    repeat (2)
    begin
      en_req = 1'b0;
      step(700);
      en_req = 1'b1;
      step(50);
      `CHK(sequencer_state, 3'h5)
    end
    en_req = 1'b0;
    `WAITFOR(sequencer_state === 3'h0, 1200)
    `CHK(n >= 960 && n <= 1040, 1'b1)
  endtask
  task automatic t_short_hold;
    power_up(2'h3, 2'h1);
    `CHK({channel_shorted, sink_enable}, 4'h4)
    step(200);
    `CHK(sequencer_state, 3'h3)
    led_below_short = 2'h0;
    led_above_detect = 2'h3;
    `WAITFOR(sequencer_state === 3'h2, 50)
    `CHK(sequencer_state, 3'h2)
    `WAITFOR(sequencer_state === 3'h4, 800)
    `CHK({sequencer_state, channel_unused}, 5'h10)
    lockout_clear = 1'b0;
    `WAITFOR(sequencer_state === 3'h0, 20)
    `CHK(sequencer_state, 3'h0)
  endtask
  task final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    step(12);
    reset = 1'b0;
    step(2);
    t_refused();
    t_normal();
    t_sync();
    t_sync_low();
    t_low_power();
    t_short_hold();
    final_report();
  end
  // tests need about 6k cycles; allow 40k
  initial
  begin
    #800000;
    error_cnt++;
    final_report();
  end
endmodule
